// [core/pll_spread_spectrum_modulator.sv]
// spread spectrum modulator for the fractional pll and spread fields of the second pll
`timescale 1ns/1ns
// Summary of operation
// - each profile step lasts step_time plus two detector cycles
// - one quadrant uses twice samples_per_quadrant deltas; software programs 1 to 6
// - waveform is four mirrored quadrants built from the same samples
// - modulation rate is detector rate over four times samples times step cycles
// - six-bit offset sets fractional offset; zero means center spread
// - nonzero offset gives down spread about ideal minus one plus offset
// - twelve four-bit delta samples are held; only selected ones used
// - dither bit randomizes the lsb of the modulator input
// - doubling bit doubles the accumulated total and amplitude
// - waveform starts at offset; each later point adds the next delta in q_rise and q_neg_fall, subtracts it in q_fall and q_neg_rise
// - second pll spreads only while its enable bit is one
// - second pll spread uses eight-bit divider and sixteen-bit counter
// - second pll spread fields live in registers 0x4C through 0x85
// - step time of zero disables spreading; above zero enables it
module pll_spread_spectrum_modulator
  import ssm_pkg::*;
(
  input  wire logic                               ref_clk,
  input  wire logic                               srst,
  input  wire logic [STEP_W-1:0]                  step_time,
  input  wire logic [NSSC_W-1:0]                  samples_per_quadrant,
  input  wire logic [OFFSET_W-1:0]                spread_offset,
  input  wire logic [NUM_SAMPLES*SAMPLE_W-1:0]    profile_delta_sample,
  input  wire logic                               dither_enable,
  input  wire logic                               amplitude_double,
  input  wire logic                               spread_enable_pll_three,
  input  wire logic [7:0]                         spread_ref_divide,
  input  wire logic [15:0]                        spread_loop_counter,
  output logic                                    frac_spread_active,
  output logic signed [MOD_W-1:0]                 frac_offset,
  output logic                                    step_strobe,
  output logic                                    config_error,
  output logic                                    pll3_spread_active,
  output logic [7:0]                              pll3_ref_divide,
  output logic [15:0]                             pll3_loop_counter
);
  typedef struct packed {
    logic                    active;
    quadrant_e               quad;
    logic [3:0]              idx;
    logic [ACC_W-1:0]        acc;
    logic [15:0]             lfsr;
    logic signed [MOD_W-1:0] out;
    logic                    strobe;
    logic                    err;
    logic                    p3_act;
    logic [7:0]              p3_div;
    logic [15:0]             p3_cnt;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  ssm_step_if step ();

  ssm_step_timer u_timer (
    .ref_clk (ref_clk),
    .srst    (srst),
    .step    (step.timer)
  );

  // twelve stored deltas; the index never passes last_idx, so only the selected ones are read
  function automatic logic [SAMPLE_W-1:0] delta_at(input logic [3:0] i);
    delta_at = profile_delta_sample[i*SAMPLE_W +: SAMPLE_W];
  endfunction

  logic [3:0] last_idx;
  logic [3:0] cur_delta;
  logic [3:0] nssc_c;
  logic       run;
  logic       lfsr_fb;
  logic [ACC_W-1:0] amp;
  logic signed [MOD_W-1:0] centered;

  assign nssc_c = (samples_per_quadrant < NSSC_MIN) ? 4'(NSSC_MIN) :
                  (samples_per_quadrant > NSSC_MAX) ? 4'(NSSC_MAX) : 4'(samples_per_quadrant);
  assign last_idx = 4'(nssc_c * NSSC_MULT) - 4'h1;
  assign run = (step_time != 4'h0);
  assign step.run = run;
  assign step.step_time = step_time;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.strobe = 1'b0;
    cur_delta     = delta_at(st_r.idx);
    lfsr_fb       = ^(st_r.lfsr & LFSR_TAPS);
    amp           = amplitude_double ? {st_r.acc[ACC_W-2:0], 1'b0} : st_r.acc;
    amp[0]        = amp[0] ^ (dither_enable & st_r.lfsr[0]);
    st_nxt.lfsr   = {st_r.lfsr[14:0], lfsr_fb};
    st_nxt.active = run;
    st_nxt.err    = (samples_per_quadrant < NSSC_MIN) || (samples_per_quadrant > NSSC_MAX);
    if (!run) begin
      st_nxt.quad = q_rise;
      st_nxt.idx  = 4'h0;
      st_nxt.acc  = ACC_W'(spread_offset);
    end else if (step.tick) begin
      st_nxt.strobe = 1'b1;
      case (st_r.quad)
        q_rise, q_neg_fall: begin
          st_nxt.acc = st_r.acc + ACC_W'(cur_delta);
          if (st_r.idx == last_idx) begin
            st_nxt.quad = (st_r.quad == q_rise) ? q_fall : q_neg_rise;
          end else begin
            st_nxt.idx = st_r.idx + 4'h1;
          end
        end
        q_fall, q_neg_rise: begin
          st_nxt.acc = st_r.acc - ACC_W'(cur_delta);
          if (st_r.idx == 4'h0) begin
            st_nxt.quad = (st_r.quad == q_fall) ? q_neg_fall : q_rise;
          end else begin
            st_nxt.idx = st_r.idx - 4'h1;
          end
        end
        default: begin
          st_nxt.quad = q_rise;
        end
      endcase
    end
    // lower half-cycle mirrors the excursion below the offset point
    centered = MOD_W'(amp) - MOD_W'(amplitude_double ? {spread_offset, 1'b0} : {1'b0, spread_offset});
    if (!run) begin
      st_nxt.out = '0;
    end else if (st_r.quad == q_neg_fall || st_r.quad == q_neg_rise) begin
      st_nxt.out = MOD_W'(spread_offset) - centered;
    end else begin
      st_nxt.out = MOD_W'(spread_offset) + centered;
    end
    // these fields reach the second pll's outputs one cycle later, held at zero while its enable bit is clear
    st_nxt.p3_act = spread_enable_pll_three;
    st_nxt.p3_div = spread_enable_pll_three ? spread_ref_divide : 8'h00;
    st_nxt.p3_cnt = spread_enable_pll_three ? spread_loop_counter : 16'h0000;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r      <= '0;
      st_r.acc  <= '0;
      st_r.lfsr <= LFSR_SEED;
      st_r.quad <= q_rise;
    end else begin
      st_r <= st_nxt;
    end
  end

  // rate follows from the tick period times 4 quadrants times used samples
  assign frac_spread_active = st_r.active;
  assign frac_offset        = st_r.out;
  assign step_strobe        = st_r.strobe;
  assign config_error       = st_r.err;
  assign pll3_spread_active = st_r.p3_act;
  assign pll3_ref_divide    = st_r.p3_div;
  assign pll3_loop_counter  = st_r.p3_cnt;
endmodule

// [core/ssm_pkg.sv]
// constants and types shared by the spread spectrum modulator
package ssm_pkg;
  localparam int          NUM_SAMPLES    = 12;
  localparam int          SAMPLE_W       = 4;
  localparam int          OFFSET_W       = 6;
  localparam int          STEP_W         = 4;
  localparam int          NSSC_W         = 3;
  localparam int          ACC_W          = 8;
  localparam int          MOD_W          = 10;
  localparam logic [4:0]  STEP_EXTRA     = 5'h02;
  localparam logic [3:0]  NSSC_MULT      = 4'h2;
  localparam logic [NSSC_W-1:0] NSSC_MIN = 3'h1;
  localparam logic [NSSC_W-1:0] NSSC_MAX = 3'h6;
  localparam logic [7:0]  PLL3_ADDR_LO   = 8'h4C;
  localparam logic [7:0]  PLL3_ADDR_HI   = 8'h85;
  localparam logic [15:0] LFSR_SEED      = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS      = 16'hB400;

  typedef enum logic [1:0] {
    q_rise,
    q_fall,
    q_neg_fall,
    q_neg_rise
  } quadrant_e;
endpackage

// [core/ssm_step_if.sv]
// step-tick link between the modulator and its step timer
`timescale 1ns/1ns
interface ssm_step_if;
  logic       run;
  logic [3:0] step_time;
  logic       tick;
  modport timer (input run, input step_time, output tick);
  modport core (output run, output step_time, input tick);
endinterface

// [core/ssm_step_timer.sv]
// step timer: one tick every step_time + 2 detector cycles
`timescale 1ns/1ns
module ssm_step_timer
  import ssm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  ssm_step_if.timer step
);
  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } timer_s;

  timer_s st_r;
  timer_s st_nxt;

  always_comb begin
    st_nxt      = st_r;
    st_nxt.tick = 1'b0;
    if (!step.run) begin
      st_nxt.cnt = 5'h00;
    end else if (st_r.cnt == (5'(step.step_time) + STEP_EXTRA - 5'h01)) begin
      st_nxt.cnt  = 5'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 5'h01;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign step.tick = st_r.tick;
endmodule

// [bench/ssm_monitor.sv]
// port checker for the spread spectrum modulator
`timescale 1ns/1ns
module ssm_monitor
  import ssm_pkg::*;
(
  input wire logic ref_clk, srst, step_strobe, config_error, frac_spread_active,
  input wire logic pll3_spread_active, spread_enable_pll_three,
  input wire logic [STEP_W-1:0] step_time,
  input wire logic [NSSC_W-1:0] samples_per_quadrant,
  input wire logic signed [MOD_W-1:0] frac_offset,
  input wire logic [7:0] spread_ref_divide, pll3_ref_divide,
  input wire logic [15:0] spread_loop_counter, pll3_loop_counter
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_rst; $fell(srst) |-> !step_strobe && !frac_spread_active && frac_offset == 0; endproperty
  a_rst: assert property (p_rst) else $error("not clear after reset");
  property p_act; step_time != 0 |=> frac_spread_active; endproperty
  a_act: assert property (p_act) else $error("spread not active");
  property p_off; step_time == 0 && $past(step_time) == 0 && $past(step_time, 2) == 0
    |-> !step_strobe && frac_offset == 0; endproperty
  a_off: assert property (p_off) else $error("spread while off");
  property p_per; disable iff (srst || step_time != 4'h5) step_strobe |=> !step_strobe[*6] ##1 step_strobe; endproperty
  a_per: assert property (p_per) else $error("step length");
  property p_bad; samples_per_quadrant inside {3'h0, 3'h7} |=> config_error; endproperty
  a_bad: assert property (p_bad) else $error("range not flagged");
  property p_ok; samples_per_quadrant inside {[3'h1:3'h6]} |=> !config_error; endproperty
  a_ok: assert property (p_ok) else $error("false range flag");
  property p_en; spread_enable_pll_three |=> pll3_spread_active && pll3_ref_divide == $past(spread_ref_divide)
    && pll3_loop_counter == $past(spread_loop_counter); endproperty
  a_en: assert property (p_en) else $error("pll3 fields");
  property p_dis; !spread_enable_pll_three |=> !pll3_spread_active && pll3_loop_counter == 0
    && pll3_ref_divide == 0; endproperty
  a_dis: assert property (p_dis) else $error("pll3 not off");
endmodule
bind pll_spread_spectrum_modulator ssm_monitor ssm_monitor_inst (.*);

// [bench/ssm_fb_model.sv]
// feedback divider model: records the extremes of the fractional input
`timescale 1ns/1ns
module ssm_fb_model
  import ssm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic clear,
  input wire logic signed [MOD_W-1:0] frac_offset,
  output logic signed [MOD_W-1:0] peak_hi,
  output logic signed [MOD_W-1:0] peak_lo
);
  // fractional input is taken every detector cycle, even-integer multipliers too
  always @(posedge ref_clk) begin
    if (clear || frac_offset > peak_hi)
      peak_hi <= frac_offset;
    if (clear || frac_offset < peak_lo)
      peak_lo <= frac_offset;
  end
endmodule

// [bench/pll_spread_spectrum_modulator_tb_top.sv]
// testbench for the spread spectrum modulator
`timescale 1ns/1ns
module pll_spread_spectrum_modulator_tb_top;
  import ssm_pkg::*;
  logic ref_clk = 0, srst = 1, dither_enable = 0, amplitude_double = 0, spread_enable_pll_three = 0, clear = 0;
  logic [STEP_W-1:0] step_time = 0;
  logic [NSSC_W-1:0] samples_per_quadrant = 1;
  logic [OFFSET_W-1:0] spread_offset = 0;
  // sample 2 is large so that using too many samples shows in the peaks
  logic [NUM_SAMPLES*SAMPLE_W-1:0] profile_delta_sample = 48'h000000000F43;
  logic [7:0] spread_ref_divide = 0, pll3_ref_divide;
  logic [15:0] spread_loop_counter = 0, pll3_loop_counter;
  logic frac_spread_active, step_strobe, config_error, pll3_spread_active;
  logic signed [MOD_W-1:0] frac_offset, peak_hi, peak_lo;
  int mismatches = 0, num_checks = 0;
  always #50 ref_clk = ~ref_clk;
  pll_spread_spectrum_modulator pll_spread_spectrum_modulator_inst (.*);
  ssm_fb_model ssm_fb_model_inst (.*);
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input logic ok, input string what);
    num_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic t_cfg;
    for (int q = 0; q < 8; q++) begin
      @(posedge ref_clk);
      samples_per_quadrant <= q[2:0];
      cyc(2);
      chk(config_error === (q == 0 || q == 7), "range flag");
    end
    @(posedge ref_clk);
    spread_ref_divide <= 8'hA5;
    spread_loop_counter <= 16'h1234;
    samples_per_quadrant <= 3'h1;
    cyc(2);
    chk(pll3_spread_active === 1'b0 && pll3_ref_divide === 8'h00, "pll3 off");
    @(posedge ref_clk);
    spread_enable_pll_three <= 1;
    cyc(2);
    chk(pll3_ref_divide === 8'hA5 && pll3_loop_counter === 16'h1234, "pll3 on");
    chk(pll3_spread_active === 1'b1, "pll3 active");
    $display("config test done");
  endtask
  task automatic t_step(input logic [3:0] st);
    int n;
    @(posedge ref_clk);
    step_time <= st;
    for (int i = 0; i < 40 && step_strobe !== 1'b1; i++) cyc(1);
    n = 0;
    do begin cyc(1); n++; end while (step_strobe !== 1'b1 && n < 40);
    chk(n == st + 2, "step length");
    chk(frac_spread_active === 1'b1, "spread on");
    @(posedge ref_clk);
    step_time <= 4'h0;
    cyc(4);
    n = 0;
    repeat (30) begin cyc(1); if (step_strobe !== 1'b0) n++; end
    chk(n == 0 && frac_offset === 10'sh000 && frac_spread_active === 1'b0, "spread off");
    $display("step test done");
  endtask
  // one modulation period: 4 quadrants * 2 samples * 7 cycles
  task automatic t_wave(input logic dbl, input logic dth, input int hi, input int lo);
    logic signed [MOD_W-1:0] s;
    @(posedge ref_clk);
    amplitude_double <= dbl;
    dither_enable <= dth;
    step_time <= 4'h5;
    clear <= 1;
    @(posedge ref_clk);
    clear <= 0;
    cyc(168);
    s = frac_offset;
    cyc(56);
    chk(dth || frac_offset === s, "period");
    chk(peak_hi >= hi && peak_hi <= 7 * (dbl + 1) && peak_lo <= -hi && peak_lo >= lo, "peaks");
    @(posedge ref_clk);
    step_time <= 4'h0;
    cyc(4);
    $display("wave test done");
  endtask
  initial begin
    cyc(16);
    @(posedge ref_clk);
    srst <= 0;
    cyc(1);
    chk(frac_offset === 10'sh000 && step_strobe === 1'b0 && config_error === 1'b0, "reset");
    t_cfg();
    t_step(4'h5);
    t_step(4'hE);
    t_wave(1'b0, 1'b0, 7, -7);
    t_wave(1'b1, 1'b0, 14, -14);
    t_wave(1'b0, 1'b1, 6, -7);
    report_and_stop();
  end
  initial begin
    #1000000;
    mismatches++;
    report_and_stop();
  end
endmodule
